// ===== sbsp_consts.svh
// constants of the synchronous burst sram port
// assumes inclusion by the package and by every design file except the fifo
`ifndef SBSP_CONSTS_SVH
`define SBSP_CONSTS_SVH
`define SBSP_ADDR_W 18
`define SBSP_LANES 4
`define SBSP_LANE_W 9
`define SBSP_BYTE_W 8
`define SBSP_DATA_W 32
`define SBSP_FIFO_DEPTH 32
`define SBSP_LO_W 2
`define SBSP_LO_ZERO 2'h0
`define SBSP_LO_ONE 2'h1
`define SBSP_MASK_NONE 4'h0
`define SBSP_SYNC_W 3
`endif

// ===== sbsp_ctrl_model.sv
// memory controller model driving the command and write-data pins of the port
// assumes it shares the port's clock; each task waits for the next rising edge before it drives
`include "sbsp_consts.svh"
module sbsp_ctrl_model
   import sbsp_pkg::*;
(
   // clock
   input wire logic i_clock,
   // command pins
   output sbsp_addr_t o_address,
   output logic o_chip_select_first_n,
   output logic o_chip_select_second,
   output logic o_chip_select_third_n,
   output logic o_advance_or_load,
   output logic o_write_select_n,
   output sbsp_lanes_t o_byte_lane_write_n,
   output logic o_clock_qualifier_n,
   output logic o_sleep_request,
   // write data lines
   output logic [`SBSP_DATA_W-1:0] o_dq,
   output sbsp_lanes_t o_parity_lines
);
   timeunit 1ns;
   timeprecision 1ps;

   // power-up: device deselected, awake
   initial begin
      o_address = '0;
      {o_chip_select_first_n, o_chip_select_second, o_chip_select_third_n} = 3'h6;
      o_advance_or_load = 1'b0;
      o_write_select_n = 1'b1;
      o_byte_lane_write_n = 4'hf;
      o_clock_qualifier_n = 1'b0;
      o_sleep_request = 1'b0;
      o_dq = '0;
      o_parity_lines = '0;
   end

   // one command edge; pins change just after the edge and hold until the next
   task automatic cmd(input logic [2:0] sel, input logic adv, input logic we_n,
         input sbsp_lanes_t bw_n, input logic cen_n, input sbsp_addr_t addr,
         input logic dv, input logic [`SBSP_DATA_W-1:0] d, input sbsp_lanes_t p);
      @(posedge i_clock);
      {o_chip_select_first_n, o_chip_select_second, o_chip_select_third_n} <= sel;
      o_advance_or_load <= adv;
      o_write_select_n <= we_n;
      o_byte_lane_write_n <= bw_n;
      o_clock_qualifier_n <= cen_n;
      o_address <= addr;
      if (dv) begin
         o_dq <= d;
         o_parity_lines <= p;
      end else begin
         // released lines show the inverse of the last value
         o_dq <= ~o_dq;
         o_parity_lines <= ~o_parity_lines;
      end
   endtask : cmd

   task automatic sleep_set(input logic on);
      @(posedge i_clock);
      o_chip_select_first_n <= 1'b1;
      o_advance_or_load <= 1'b0;
      o_sleep_request <= on;
   endtask : sleep_set
endmodule : sbsp_ctrl_model

// ===== sbsp_fifo.sv
// first-in first-out buffer with valid and ready on both sides
// assumes a power-of-two depth and one clock
module sbsp_fifo
   import sbsp_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_reset_n,
   // filling side
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   // draining side
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = DEPTH[AW:0];

   logic [WIDTH-1:0] store [0:DEPTH-1];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   // handshakes
   assign o_in_ready = (count != FULL);
   assign o_out_valid = (count != '0);
   assign o_out_data = store[rd_ptr];
   assign push = i_in_valid & o_in_ready;
   assign pop = o_out_valid & i_out_ready;

   // pointers and fill level
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) wr_ptr <= wr_ptr + 1'b1;
         if (pop) rd_ptr <= rd_ptr + 1'b1;
         if (push & ~pop) count <= count + 1'b1;
         else if (pop & ~push) count <= count - 1'b1;
      end
   end

   // storage
   always_ff @(posedge i_clock) begin
      if (push) store[wr_ptr] <= i_in_data;
   end

endmodule : sbsp_fifo

// ===== sbsp_mem.sv
// sram array with lane-masked write port and registered read port
// assumes one clock; a read of the word being written sees the new lanes
`include "sbsp_consts.svh"
module sbsp_mem
   import sbsp_pkg::*;
(
   // clock and reset
   input wire logic i_clock,
   input wire logic i_reset_n,
   // write port
   input wire logic i_wr_en,
   input wire sbsp_addr_t i_wr_addr,
   input wire sbsp_lanes_t i_wr_mask,
   input wire sbsp_word_t i_wr_data,
   // read port
   input wire sbsp_addr_t i_rd_addr,
   output sbsp_word_t o_rd_data
);
   sbsp_word_t store [0:(1 << `SBSP_ADDR_W)-1];
   logic hit;

   assign hit = i_wr_en & (i_wr_addr == i_rd_addr);

   // lane write, unselected lanes kept
   always_ff @(posedge i_clock) begin
      for (int k = 0; k < `SBSP_LANES; k++) begin
         if (i_wr_en & i_wr_mask[k]) store[i_wr_addr][k] <= i_wr_data[k];
      end
   end

   // read register, new data wins on a collision
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_rd_data <= '0;
      end else begin
         for (int k = 0; k < `SBSP_LANES; k++) begin
            o_rd_data[k] <= (hit & i_wr_mask[k]) ? i_wr_data[k] : store[i_rd_addr][k];
         end
      end
   end

endmodule : sbsp_mem

// ===== sbsp_pkg.sv
// types shared by the sram port, its memory and its write fifo
// assumes sbsp_consts.svh is on the include path
package sbsp_pkg;
`include "sbsp_consts.svh"

   // one 36-bit word, four lanes of byte plus parity
   typedef logic [`SBSP_LANES-1:0][`SBSP_LANE_W-1:0] sbsp_word_t;
   typedef logic [`SBSP_ADDR_W-1:0] sbsp_addr_t;
   typedef logic [`SBSP_LANES-1:0] sbsp_lanes_t;

   // cycle type held between edges
   typedef enum logic [1:0] {
      SBSP_DESEL, SBSP_READ, SBSP_WRITE, SBSP_SLEEP
   } sbsp_mode_t;

   // decoded operation of one clock edge
   typedef enum logic [2:0] {
      SBSP_OP_STALL, SBSP_OP_DESEL, SBSP_OP_READ,
      SBSP_OP_WRITE, SBSP_OP_ABORT, SBSP_OP_CONT
   } sbsp_op_t;

   // one queued array write; mask bit high writes that lane
   typedef struct packed {
      sbsp_addr_t addr;
      sbsp_lanes_t mask;
      sbsp_word_t data;
   } sbsp_wr_t;

   // all state of the port
   typedef struct packed {
      sbsp_mode_t mode;
      logic [`SBSP_ADDR_W-1:`SBSP_LO_W] base;
      logic [`SBSP_LO_W-1:0] start;
      logic [`SBSP_LO_W-1:0] count;
      logic wr_pending;
      sbsp_lanes_t wr_mask;
      sbsp_addr_t wr_addr;
      logic [`SBSP_SYNC_W-1:0] sleep_sync;
      logic asleep;
      sbsp_lanes_t fwd_mask;
      sbsp_word_t fwd_data;
   } sbsp_state_t;

endpackage : sbsp_pkg

// ===== sbsp_port.sv
// synchronous flow-through burst sram port, device side
// assumes a memory controller on the same clock drives the command pins
`include "sbsp_consts.svh"
module sbsp_port
   import sbsp_pkg::*;
(
   // clock and reset
   input wire logic i_clock,
   input wire logic i_reset_n,
   // command pins
   input wire sbsp_addr_t i_address,
   input wire logic i_chip_select_first_n,
   input wire logic i_chip_select_second,
   input wire logic i_chip_select_third_n,
   input wire logic i_advance_or_load,
   input wire logic i_write_select_n,
   input wire sbsp_lanes_t i_byte_lane_write_n,
   input wire logic i_clock_qualifier_n,
   input wire logic i_burst_order,
   // asynchronous pins
   input wire logic i_sleep_request,
   input wire logic i_output_enable_n,
   // data and parity lines
   input wire logic [`SBSP_DATA_W-1:0] i_dq,
   input wire sbsp_lanes_t i_parity_lines,
   output logic [`SBSP_DATA_W-1:0] o_dq,
   output sbsp_lanes_t o_parity_lines,
   output logic o_dq_oe_n
);

   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------

   // burst low bits for a given step
   function automatic logic [`SBSP_LO_W-1:0] burst_lo(
      input logic [`SBSP_LO_W-1:0] start,
      input logic [`SBSP_LO_W-1:0] step,
      input logic order);
      if (order) return start ^ step;
      return `SBSP_LO_W'(start + step);
   endfunction : burst_lo

   // overlay the masked lanes of one word onto another
   function automatic sbsp_word_t merge(
      input sbsp_word_t base,
      input sbsp_lanes_t mask,
      input sbsp_word_t over);
      sbsp_word_t res;
      res = base;
      for (int k = 0; k < `SBSP_LANES; k++) begin
         if (mask[k]) res[k] = over[k];
      end
      return res;
   endfunction : merge

   // -------------------------------------------------------------
   // signals
   // -------------------------------------------------------------
   sbsp_state_t q;
   sbsp_state_t next_q;
   sbsp_op_t op;
   sbsp_word_t in_word;
   sbsp_word_t mem_word;
   sbsp_word_t rd_word;
   sbsp_addr_t rd_addr;
   sbsp_wr_t push_item;
   sbsp_wr_t head;
   logic push_valid;
   logic push_ready;
   logic head_valid;
   logic taken;
   logic drive;

   // pack the lines into lanes and unpack the read word
   for (genvar k = 0; k < `SBSP_LANES; k++) begin : g_lane
      assign in_word[k] = {i_parity_lines[k], i_dq[k*`SBSP_BYTE_W +: `SBSP_BYTE_W]};
      assign o_dq[k*`SBSP_BYTE_W +: `SBSP_BYTE_W] = rd_word[k][`SBSP_BYTE_W-1:0];
      assign o_parity_lines[k] = rd_word[k][`SBSP_BYTE_W];
   end

   // -------------------------------------------------------------
   // edge decode
   // -------------------------------------------------------------

   // classify the command pins of this edge
   always_comb begin
      op = SBSP_OP_STALL;
      // qualifier high leaves the edge as a stall
      if (!i_clock_qualifier_n) begin
         if (i_advance_or_load) begin
            op = SBSP_OP_CONT;
         // any chip select inactive on a load
         end else if (i_chip_select_first_n | ~i_chip_select_second |
                      i_chip_select_third_n) begin
            op = SBSP_OP_DESEL;
         end else if (i_write_select_n) begin
            op = SBSP_OP_READ;
         // write start with no lane is an abort
         end else if (&i_byte_lane_write_n) begin
            op = SBSP_OP_ABORT;
         end else begin
            op = SBSP_OP_WRITE;
         end
      end
   end

   // a full write queue stalls the edge like the qualifier
   assign taken = ~i_clock_qualifier_n & ~q.asleep & push_ready;
   assign push_valid = q.wr_pending & ~i_clock_qualifier_n & ~q.asleep;

   // data of the previous address edge joins its address
   assign push_item = '{addr: q.wr_addr, mask: q.wr_mask, data: in_word};

   // -------------------------------------------------------------
   // next state
   // -------------------------------------------------------------
   always_comb begin
      next_q = q;
      // three-stage synchroniser on the sleep request
      next_q.sleep_sync = {q.sleep_sync[`SBSP_SYNC_W-2:0], i_sleep_request};
      if (q.sleep_sync[`SBSP_SYNC_W-2] == q.sleep_sync[`SBSP_SYNC_W-1]) begin
         next_q.asleep = q.sleep_sync[`SBSP_SYNC_W-1];
      end
      if (q.asleep) begin
         // sleep drops the pending write and undrives the lines
         next_q.mode = SBSP_SLEEP;
         next_q.wr_pending = 1'b0;
      end else if (q.mode == SBSP_SLEEP) begin
         next_q.mode = SBSP_DESEL;
      end else if (taken) begin
         next_q.wr_pending = 1'b0;
         next_q.fwd_mask = `SBSP_MASK_NONE;
         unique case (op)
            SBSP_OP_STALL: begin
            end
            SBSP_OP_DESEL: begin
               next_q.mode = SBSP_DESEL;
            end
            SBSP_OP_READ: begin
               // load external address; also for a dummy read
               next_q.mode = SBSP_READ;
               next_q.base = i_address[`SBSP_ADDR_W-1:`SBSP_LO_W];
               next_q.start = i_address[`SBSP_LO_W-1:0];
               next_q.count = `SBSP_LO_ZERO;
            end
            SBSP_OP_WRITE, SBSP_OP_ABORT: begin
               // load address, data follows on the next edge
               next_q.mode = SBSP_WRITE;
               next_q.base = i_address[`SBSP_ADDR_W-1:`SBSP_LO_W];
               next_q.start = i_address[`SBSP_LO_W-1:0];
               next_q.count = `SBSP_LO_ZERO;
               next_q.wr_pending = (op == SBSP_OP_WRITE);
               next_q.wr_mask = ~i_byte_lane_write_n;
               next_q.wr_addr = i_address;
            end
            SBSP_OP_CONT: begin
               if (q.mode != SBSP_DESEL) begin
                  // step the burst; two bits wrap after four
                  next_q.count = q.count + `SBSP_LO_ONE;
               end
               // write next address; no lane writes nothing
               if (q.mode == SBSP_WRITE && !(&i_byte_lane_write_n)) begin
                  next_q.wr_pending = 1'b1;
                  next_q.wr_mask = ~i_byte_lane_write_n;
                  next_q.wr_addr = {q.base,
                     burst_lo(q.start, next_q.count, i_burst_order)};
               end
            end
         endcase
      end
      // same-edge write to the word now read is forwarded
      // read address rebuilt here so this process never reads its own result
      if (taken && push_valid && next_q.mode == SBSP_READ && push_item.addr ==
          {next_q.base, burst_lo(next_q.start, next_q.count, i_burst_order)}) begin
         next_q.fwd_mask = push_item.mask;
         next_q.fwd_data = push_item.data;
      end
   end

   // array read follows the next address, no output stage
   assign rd_addr = {next_q.base, burst_lo(next_q.start, next_q.count, i_burst_order)};

   // state register
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         q <= '{mode: SBSP_DESEL, sleep_sync: '0, asleep: 1'b0, default: '0};
      end else begin
         q <= next_q;
      end
   end

   // -------------------------------------------------------------
   // write queue and array
   // -------------------------------------------------------------

   // queued writes drain while awake
   sbsp_fifo #(
      .WIDTH($bits(sbsp_wr_t)),
      .DEPTH(`SBSP_FIFO_DEPTH)
   ) u_fifo (
      .i_clock(i_clock),
      .i_reset_n(i_reset_n),
      .i_in_valid(push_valid),
      .o_in_ready(push_ready),
      .i_in_data(push_item),
      .o_out_valid(head_valid),
      .i_out_ready(~q.asleep),
      .o_out_data(head)
   );

   sbsp_mem u_mem (
      .i_clock(i_clock),
      .i_reset_n(i_reset_n),
      .i_wr_en(head_valid & ~q.asleep),
      .i_wr_addr(head.addr),
      .i_wr_mask(head.mask),
      .i_wr_data(head.data),
      .i_rd_addr(rd_addr),
      .o_rd_data(mem_word)
   );

   assign rd_word = merge(mem_word, q.fwd_mask, q.fwd_data);

   // -------------------------------------------------------------
   // line drive
   // -------------------------------------------------------------

   // cycle type gated by the raw output enable
   // only a read cycle lets the enable through
   assign drive = (q.mode == SBSP_READ) & ~i_output_enable_n;
   // write, deselect and sleep leave the lines undriven
   assign o_dq_oe_n = ~drive;

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   a_desel_tristate: assert property (
      @(posedge i_clock) disable iff (!i_reset_n)
      (taken && op == SBSP_OP_DESEL && !q.asleep) |=> o_dq_oe_n)
      else $error("lines driven after deselect");

   a_write_tristate: assert property (
      @(posedge i_clock) disable iff (!i_reset_n)
      (taken && op == SBSP_OP_WRITE) |=> o_dq_oe_n)
      else $error("lines driven in write cycle");

   a_dummy_read: assert property (
      @(posedge i_clock) disable iff (!i_reset_n)
      (taken && op == SBSP_OP_READ) ##1 i_output_enable_n |-> o_dq_oe_n)
      else $error("dummy read drove the lines");

   a_read_drive: assert property (
      @(posedge i_clock) disable iff (!i_reset_n)
      (taken && op == SBSP_OP_READ && q.mode != SBSP_SLEEP) ##1 !i_output_enable_n
      |-> !o_dq_oe_n)
      else $error("enabled read not driven");

   a_stall_hold: assert property (
      @(posedge i_clock) disable iff (!i_reset_n)
      (i_clock_qualifier_n && !q.asleep && q.mode != SBSP_SLEEP)
      |=> $stable(q.mode) && $stable(q.count) && $stable(q.base))
      else $error("stalled edge changed state");

   a_burst_wrap: assert property (
      @(posedge i_clock) disable iff (!i_reset_n)
      (taken && op == SBSP_OP_READ) ##1 (taken && op == SBSP_OP_CONT) [*4]
      |=> q.count == `SBSP_LO_ZERO)
      else $error("burst did not wrap after four");

   a_abort_quiet: assert property (
      @(posedge i_clock) disable iff (!i_reset_n)
      (taken && op == SBSP_OP_ABORT) |=> !q.wr_pending && o_dq_oe_n)
      else $error("abort queued a write");

   a_data_next: assert property (
      @(posedge i_clock) disable iff (!i_reset_n)
      (taken && op == SBSP_OP_WRITE && q.mode != SBSP_SLEEP)
      |=> q.wr_pending && q.wr_addr == $past(i_address))
      else $error("write address not held for data edge");

   a_sleep_undrive: assert property (
      @(posedge i_clock) disable iff (!i_reset_n)
      q.asleep |=> q.mode == SBSP_SLEEP && o_dq_oe_n)
      else $error("sleep did not undrive the lines");

   a_interleave: assert property (
      @(posedge i_clock) disable iff (!i_reset_n)
      (taken && op == SBSP_OP_CONT && q.mode == SBSP_READ && i_burst_order)
      |-> rd_addr[`SBSP_LO_W-1:0] == (q.start ^ `SBSP_LO_W'(q.count + `SBSP_LO_ONE)))
      else $error("interleaved step wrong");

endmodule : sbsp_port

// ===== sync_burst_sram_port_test.sv
// self-checking bench of the burst sram port
// assumes the controller model drives command and data pins; bench drives oe and order
`include "sbsp_consts.svh"
module sync_burst_sram_port_test import sbsp_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   typedef logic [`SBSP_DATA_W-1:0] sbsp_dq_t;
   typedef struct {sbsp_addr_t a; sbsp_lanes_t bw; sbsp_dq_t d; sbsp_lanes_t p;
      sbsp_dq_t ed; sbsp_lanes_t ep;} sbsp_row_t;
   localparam logic [2:0] SEL = 3'h2;
   localparam logic [2:0] DES = 3'h6;
   localparam sbsp_addr_t BASE = 18'h00120;
   logic i_clock, i_reset_n, oe_n, order, cs1_n, cs2, cs3_n, adv, we_n, cen_n, slp, oe_out;
   logic wv;
   sbsp_addr_t addr;
   sbsp_lanes_t bw_n, par_in, par_out, wp;
   sbsp_dq_t dq_in, dq_out, wd;
   sbsp_dq_t mdq [sbsp_addr_t];
   sbsp_lanes_t mpr [sbsp_addr_t];
   sbsp_row_t rows [4];
   int num_errors, n_tests;

   sbsp_port sbsp_port_inst (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_address(addr),
      .i_chip_select_first_n(cs1_n), .i_chip_select_second(cs2),
      .i_chip_select_third_n(cs3_n), .i_advance_or_load(adv), .i_write_select_n(we_n),
      .i_byte_lane_write_n(bw_n), .i_clock_qualifier_n(cen_n), .i_burst_order(order),
      .i_sleep_request(slp), .i_output_enable_n(oe_n), .i_dq(dq_in),
      .i_parity_lines(par_in), .o_dq(dq_out), .o_parity_lines(par_out), .o_dq_oe_n(oe_out));
   sbsp_ctrl_model sbsp_ctrl_model_inst (.i_clock(i_clock), .o_address(addr),
      .o_chip_select_first_n(cs1_n), .o_chip_select_second(cs2),
      .o_chip_select_third_n(cs3_n), .o_advance_or_load(adv), .o_write_select_n(we_n),
      .o_byte_lane_write_n(bw_n), .o_clock_qualifier_n(cen_n), .o_sleep_request(slp),
      .o_dq(dq_in), .o_parity_lines(par_in));

   // 250 MHz clock
   initial begin
      i_clock = 1'b0;
      forever #2 i_clock = ~i_clock;
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic sbsp_addr_t ba(input logic [1:0] lo);
      return {BASE[`SBSP_ADDR_W-1:2], lo};
   endfunction : ba

   task automatic cmp(input logic [35:0] got, input logic [35:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp

   // expected drive state, and data when driven
   task automatic look(input logic oe, input sbsp_dq_t d, input sbsp_lanes_t p);
      cmp({35'h0, oe_out}, {35'h0, oe});
      if (oe === 1'b0) cmp({par_out, dq_out}, {p, d});
   endtask : look

   task automatic chk(input logic oe, input sbsp_dq_t d, input sbsp_lanes_t p);
      @(negedge i_clock);
      look(oe, d, p);
   endtask : chk

   task automatic rdx(input sbsp_addr_t a);
      chk(1'b0, mdq[a], mpr[a]);
   endtask : rdx

   // command edge carrying any pending write data
   task automatic op(input logic [2:0] s, input logic a_d, input logic w_n,
         input sbsp_lanes_t b, input logic c, input sbsp_addr_t a);
      sbsp_ctrl_model_inst.cmd(s, a_d, w_n, b, c, a, wv, wd, wp);
      wv = 1'b0;
   endtask : op

   // queue data for the next edge and update the expected array
   task automatic wdat(input sbsp_addr_t a, input sbsp_lanes_t b, input sbsp_dq_t d,
         input sbsp_lanes_t p);
      wv = 1'b1;
      wd = d;
      wp = p;
      if (!mdq.exists(a)) begin
         mdq[a] = 'x;
         mpr[a] = 'x;
      end
      for (int k = 0; k < 4; k++) begin
         if (!b[k]) begin
            mdq[a][8*k+:8] = d[8*k+:8];
            mpr[a][k] = p[k];
         end
      end
   endtask : wdat

   task automatic end_sim();
      $display("tests %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      i_reset_n = 1'b0;
      oe_n = 1'b0;
      order = 1'b0;
      wv = 1'b0;
      wd = '0;
      wp = '0;
      num_errors = 0;
      n_tests = 0;
      rows = '{'{18'h00010, 4'h0, 32'h11223344, 4'h5, 32'h11223344, 4'h5},
               '{18'h00010, 4'he, 32'haabbccdd, 4'ha, 32'h112233dd, 4'h4},
               '{18'h00010, 4'h6, 32'h55667788, 4'hf, 32'h55223388, 4'hd},
               '{18'h3ffff, 4'h0, 32'hdeadbeef, 4'h3, 32'hdeadbeef, 4'h3}};
      chk(1'b1, '0, '0);
      @(posedge i_clock);
      i_reset_n <= 1'b1;
      // lane writes read back on the data edge
      foreach (rows[i]) begin
         op(SEL, 1'b0, 1'b0, rows[i].bw, 1'b0, rows[i].a);
         wdat(rows[i].a, rows[i].bw, rows[i].d, rows[i].p);
         op(SEL, 1'b0, 1'b1, 4'hf, 1'b0, rows[i].a);
         chk(1'b1, '0, '0);
         op(DES, 1'b0, 1'b1, 4'hf, 1'b0, '0);
         chk(1'b0, rows[i].ed, rows[i].ep);
      end
      // linear burst write from 1, wrapping to 0, selects ignored
      op(SEL, 1'b0, 1'b0, 4'h0, 1'b0, ba(2'h1));
      for (int i = 0; i < 4; i++) begin
         wdat(ba(2'(i + 1)), 4'h0, 32'(32'h10000000 + i), 4'(i));
         if (i < 3) op(DES, 1'b1, 1'b1, 4'h0, 1'b0, '0);
         else op(DES, 1'b0, 1'b1, 4'hf, 1'b0, '0);
      end
      // interleaved read burst from 2, five accesses to show the wrap
      order <= 1'b1;
      op(SEL, 1'b0, 1'b1, 4'hf, 1'b0, ba(2'h2));
      for (int i = 0; i < 5; i++) begin
         if (i < 4) op(DES, 1'b1, 1'b0, 4'h0, 1'b0, '0);
         else op(DES, 1'b0, 1'b1, 4'hf, 1'b0, '0);
         rdx(ba(2'(2 ^ i)));
      end
      // abort start, abort continue, then a lane write at the stepped address
      order <= 1'b0;
      op(SEL, 1'b0, 1'b0, 4'hf, 1'b0, ba(2'h0));
      op(DES, 1'b1, 1'b1, 4'hf, 1'b0, '0);
      chk(1'b1, '0, '0);
      op(DES, 1'b1, 1'b1, 4'he, 1'b0, '0);
      chk(1'b1, '0, '0);
      wdat(ba(2'h2), 4'he, 32'h0a0b0c0d, 4'h0);
      op(SEL, 1'b0, 1'b1, 4'hf, 1'b0, ba(2'h0));
      chk(1'b1, '0, '0);
      for (int i = 0; i < 3; i++) begin
         op(DES, (i < 2) ? 1'b1 : 1'b0, 1'b1, 4'hf, 1'b0, '0);
         rdx(ba(2'(i)));
      end
      // dummy reads, then output enable taken low at an edge and looked at at once
      oe_n <= 1'b1;
      op(SEL, 1'b0, 1'b1, 4'hf, 1'b0, ba(2'h3));
      op(DES, 1'b1, 1'b1, 4'hf, 1'b0, '0);
      chk(1'b1, '0, '0);
      op(DES, 1'b1, 1'b1, 4'hf, 1'b0, '0);
      chk(1'b1, '0, '0);
      // the continue pins still stand at this edge, so the burst is now at 1
      @(posedge i_clock);
      oe_n <= 1'b0;
      #1;
      look(1'b0, mdq[ba(2'h1)], mpr[ba(2'h1)]);
      // stall edge between load and advance
      op(SEL, 1'b0, 1'b1, 4'hf, 1'b0, ba(2'h1));
      op(SEL, 1'b0, 1'b0, 4'h0, 1'b1, ba(2'h3));
      rdx(ba(2'h1));
      op(DES, 1'b1, 1'b1, 4'hf, 1'b0, '0);
      rdx(ba(2'h1));
      op(DES, 1'b0, 1'b1, 4'hf, 1'b0, '0);
      rdx(ba(2'h2));
      op(DES, 1'b1, 1'b1, 4'hf, 1'b0, '0);
      chk(1'b1, '0, '0);
      op(DES, 1'b1, 1'b1, 4'hf, 1'b0, '0);
      chk(1'b1, '0, '0);
      // sleep: reads ignored, port works again after wake
      sbsp_ctrl_model_inst.sleep_set(1'b1);
      repeat (5) op(DES, 1'b0, 1'b1, 4'hf, 1'b0, '0);
      op(SEL, 1'b0, 1'b1, 4'hf, 1'b0, ba(2'h0));
      op(SEL, 1'b0, 1'b1, 4'hf, 1'b0, ba(2'h0));
      chk(1'b1, '0, '0);
      sbsp_ctrl_model_inst.sleep_set(1'b0);
      repeat (6) op(DES, 1'b0, 1'b1, 4'hf, 1'b0, '0);
      op(SEL, 1'b0, 1'b1, 4'hf, 1'b0, ba(2'h3));
      op(DES, 1'b0, 1'b1, 4'hf, 1'b0, '0);
      rdx(ba(2'h3));
      end_sim();
   end
endmodule : sync_burst_sram_port_test
